// ==== rtl/boot_byte_if.sv ====
interface boot_byte_if;
  logic       valid;
  logic [7:0] data;
  logic       clear;
  logic [31:0] crc;
  modport loader (output valid, output data, output clear, input crc);
  modport engine (input valid, input data, input clear, output crc);
endinterface

// ==== rtl/boot_pkg.sv ====
package boot_pkg;
  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned RESET_WAIT_CLKS  = 750_000;
  localparam logic [31:0] CRC_POLY         = 32'hEDB8_8320;
  localparam logic [31:0] CRC_INIT         = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_SKIP         = 32'h0D15_AB1E;
  localparam int unsigned SECURE_BOOT_BIT  = 5;
  localparam int unsigned SPI_HALF_CLKS    = 20;
  localparam logic [7:0]  SPI_READ_CMD     = 8'h03;
  localparam int unsigned SPI_HDR_BITS     = 32;
  localparam int unsigned RAM_AW           = 12;
  localparam logic [2:0]  OUT_DIV_R00      = 3'h1;
  localparam logic [11:0] F_R00            = 12'h07A;
  localparam logic [2:0]  OUT_DIV_R11      = 3'h2;
  localparam logic [11:0] F_R11            = 12'h077;
  localparam logic [2:0]  OUT_DIV_R10      = 3'h2;
  localparam logic [11:0] F_R10            = 12'h031;
  localparam logic [2:0]  OUT_DIV_R01      = 3'h2;
  localparam logic [11:0] F_R01            = 12'h017;
  localparam logic [5:0]  R_RESET          = 6'h00;

  typedef enum logic [1:0] {
    SRC_JTAG, SRC_RESERVED, SRC_LINK, SRC_SPI
  } boot_src_e;
endpackage

// ==== rtl/crc32_byte.sv ====
module crc32_byte
  import boot_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  boot_byte_if.engine bus
);
  typedef struct packed {
    logic [31:0] crc;
  } crc_state_s;

  crc_state_s st_ff;
  crc_state_s nxt_st;

  always_comb begin
    logic [31:0] c;
    c = st_ff.crc;
    nxt_st = st_ff;
    if (bus.clear) begin
      nxt_st.crc = CRC_INIT;
    end else if (bus.valid) begin
      c = c ^ {24'h00_0000, bus.data};
      for (int i = 0; i < 8; i++) begin
        c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      nxt_st.crc = c;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{crc: CRC_INIT};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bus.crc = ~st_ff.crc;
endmodule

// ==== rtl/reset_boot_pll_loader.sv ====
// Function
// - hold reset, pins hi-z while reset low
// - wait 750000 clocks, then pulls, boot
// - straps 3:2 pick jtag/reserved/link/spi
// - secure bit 5 forces otp boot
// - image is size, words, crc; skip value
// - size and crc least byte first
// - load from address zero, start there
// - crc covers size and program bytes
// - reflected edb88320, init all ones, invert
// - pll ratio straps set divider, multiplier
// - tile clock from multiplier and dividers
// - software may rewrite pll fields
// - source strap picks resonator or 20mhz
// - spi master mode 0, read at 0
// - spi bytes arrive least bit first
module reset_boot_pll_loader
  import boot_pkg::*;
#(
  // post-reset wait length; a bench may shorten it to keep runs brief
  parameter int unsigned WAIT_CLKS = RESET_WAIT_CLKS
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        chip_reset_n,
  input  wire logic        pll_ratio_strap_lo,
  input  wire logic        pll_ratio_strap_hi,
  input  wire logic [1:0]  boot_source_straps,
  input  wire logic        oscillator_source_strap,
  input  wire logic [31:0] security_reg,
  input  wire logic        pll_wr,
  input  wire logic [2:0]  pll_wr_output_divider,
  input  wire logic [11:0] pll_wr_feedback_multiplier,
  input  wire logic [5:0]  pll_wr_reference_divider,
  input  wire logic        ext_byte_valid,
  input  wire logic [7:0]  ext_byte_data,
  input  wire logic        spi_miso,
  output logic             spi_sclk,
  output logic             spi_ss_n,
  output logic             spi_mosi,
  output logic             gpio_hiz,
  output logic             gpio_pull_en,
  output logic             use_onchip_osc,
  output logic [2:0]       output_divider,
  output logic [11:0]      feedback_multiplier,
  output logic [5:0]       reference_divider,
  output logic [1:0]       boot_source,
  output logic             ram_we,
  output logic [11:0]      ram_addr,
  output logic [31:0]      ram_wdata,
  output logic             boot_done,
  output logic             boot_halted,
  output logic             crc_error,
  output logic [11:0]      start_addr
);
  typedef enum logic [2:0] {
    ST_RESET, ST_WAIT, ST_DECIDE, ST_LOAD, ST_JUMP, ST_HALT, ST_IDLE
  } phase_e;

  typedef struct packed {
    phase_e      phase;
    logic [19:0] cnt;
    logic        hiz;
    logic        pulls;
    logic        onchip;
    logic [2:0]  out_div;
    logic [11:0] f;
    logic [5:0]  r;
    logic [1:0]  src;
    logic [1:0]  bidx;
    logic [1:0]  part;
    logic [31:0] word;
    logic [31:0] size;
    logic [31:0] left;
    logic [11:0] addr;
    logic        we;
    logic [31:0] wdata;
    logic        done;
    logic        halted;
    logic        err;
    logic        sclk;
    logic        ss_n;
    logic        mosi;
    logic [5:0]  half;
    logic [5:0]  hdr;
    logic [2:0]  bit_i;
    logic [7:0]  sh;
  } loader_s;

  localparam logic [1:0] PART_SIZE = 2'h0;
  localparam logic [1:0] PART_PROG = 2'h1;
  localparam logic [1:0] PART_CRC  = 2'h2;
  localparam logic [31:0] SPI_HDR  = {SPI_READ_CMD, 24'h00_0000};

  loader_s st_ff;
  loader_s nxt_st;
  logic    byte_v;
  logic [7:0] byte_d;

  boot_byte_if crc_bus ();

  crc32_byte u_crc (
    .clk (clk),
    .rst (rst),
    .bus (crc_bus.engine)
  );

  // byte source: spi shifter or link byte stream
  always_comb begin
    byte_v = 1'b0;
    byte_d = 8'h00;
    if (st_ff.phase == ST_LOAD) begin
      if (st_ff.src == SRC_SPI) begin
        byte_v = st_ff.hdr == 6'd0 && st_ff.half == 6'd0 && st_ff.sclk
                 && st_ff.bit_i == 3'd7;
        byte_d = {spi_miso, st_ff.sh[7:1]};
      end else begin
        byte_v = ext_byte_valid;
        byte_d = ext_byte_data;
      end
    end
  end

  // crc sees size and program bytes only
  assign crc_bus.valid = byte_v && st_ff.part != PART_CRC;
  assign crc_bus.data  = byte_d;
  assign crc_bus.clear = st_ff.phase == ST_DECIDE;

  always_comb begin
    logic [31:0] w;
    w = {byte_d, st_ff.word[31:8]};
    nxt_st = st_ff;
    nxt_st.we = 1'b0;
    if (!chip_reset_n) begin
      nxt_st.phase = ST_RESET;
      nxt_st.hiz   = 1'b1;
      nxt_st.pulls = 1'b0;
      nxt_st.cnt   = 20'd0;
      nxt_st.ss_n  = 1'b1;
      nxt_st.sclk  = 1'b0;
      nxt_st.mosi  = 1'b0;
      // a new boot must not inherit the verdict of the last one
      nxt_st.done   = 1'b0;
      nxt_st.halted = 1'b0;
      nxt_st.err    = 1'b0;
    end else begin
      case (st_ff.phase)
        ST_RESET: begin
          nxt_st.phase = ST_WAIT;
          nxt_st.cnt   = 20'd0;
        end
        ST_WAIT: begin
          nxt_st.cnt = st_ff.cnt + 20'd1;
          if (st_ff.cnt == 20'(WAIT_CLKS - 1)) begin
            nxt_st.phase  = ST_DECIDE;
            nxt_st.hiz    = 1'b0;
            nxt_st.pulls  = 1'b1;
            nxt_st.onchip = oscillator_source_strap;
            nxt_st.r      = R_RESET;
            case ({pll_ratio_strap_hi, pll_ratio_strap_lo})
              2'b00: begin
                nxt_st.out_div = OUT_DIV_R00;
                nxt_st.f       = F_R00;
              end
              2'b11: begin
                nxt_st.out_div = OUT_DIV_R11;
                nxt_st.f       = F_R11;
              end
              2'b10: begin
                nxt_st.out_div = OUT_DIV_R10;
                nxt_st.f       = F_R10;
              end
              default: begin
                nxt_st.out_div = OUT_DIV_R01;
                nxt_st.f       = F_R01;
              end
            endcase
          end
        end
        ST_DECIDE: begin
          nxt_st.part = PART_SIZE;
          nxt_st.bidx = 2'd0;
          nxt_st.addr = 12'h000;
          if (security_reg[SECURE_BOOT_BIT]) begin
            nxt_st.src   = SRC_LINK;
            nxt_st.phase = ST_LOAD;
          end else begin
            nxt_st.src = boot_source_straps;
            if (boot_source_straps == SRC_LINK || boot_source_straps == SRC_SPI) begin
              nxt_st.phase = ST_LOAD;
            end else begin
              nxt_st.phase = ST_IDLE;
            end
          end
          nxt_st.ss_n  = !(boot_source_straps == SRC_SPI && !security_reg[SECURE_BOOT_BIT]);
          nxt_st.hdr   = 6'(SPI_HDR_BITS);
          nxt_st.half  = 6'(SPI_HALF_CLKS - 1);
          nxt_st.mosi  = SPI_HDR[31];
          nxt_st.bit_i = 3'd0;
        end
        ST_LOAD: begin
          if (st_ff.src == SRC_SPI) begin
            // mode 0: mosi set on falling, miso sampled at the same falling edge
            if (st_ff.half == 6'd0) begin
              nxt_st.half = 6'(SPI_HALF_CLKS - 1);
              nxt_st.sclk = !st_ff.sclk;
              if (st_ff.sclk) begin
                if (st_ff.hdr != 6'd0) begin
                  nxt_st.hdr  = st_ff.hdr - 6'd1;
                  nxt_st.mosi = st_ff.hdr > 6'd1 ? SPI_HDR[5'(st_ff.hdr - 6'd2)] : 1'b0;
                end else begin
                  nxt_st.sh    = {spi_miso, st_ff.sh[7:1]};
                  nxt_st.bit_i = st_ff.bit_i + 3'd1;
                end
              end
            end else begin
              nxt_st.half = st_ff.half - 6'd1;
            end
          end
          if (byte_v) begin
            nxt_st.word = w;
            nxt_st.bidx = st_ff.bidx + 2'd1;
            if (st_ff.bidx == 2'd3) begin
              case (st_ff.part)
                PART_SIZE: begin
                  nxt_st.size = w;
                  nxt_st.left = w;
                  nxt_st.part = w == 32'h0000_0000 ? PART_CRC : PART_PROG;
                end
                PART_PROG: begin
                  nxt_st.we    = 1'b1;
                  nxt_st.wdata = w;
                  nxt_st.left  = st_ff.left - 32'd1;
                  if (st_ff.left == 32'd1) begin
                    nxt_st.part = PART_CRC;
                  end
                end
                default: begin
                  nxt_st.ss_n  = 1'b1;
                  nxt_st.sclk  = 1'b0;
                  if (w == CRC_SKIP || w == crc_bus.crc) begin
                    nxt_st.phase = ST_JUMP;
                  end else begin
                    nxt_st.phase = ST_HALT;
                    nxt_st.err   = 1'b1;
                  end
                end
              endcase
            end
          end
          if (st_ff.we) begin
            nxt_st.addr = st_ff.addr + 12'h001;
          end
        end
        ST_JUMP: begin
          nxt_st.done = 1'b1;
        end
        ST_HALT: begin
          nxt_st.halted = 1'b1;
        end
        ST_IDLE: begin
          nxt_st.halted = 1'b0;
        end
        default: begin
          nxt_st.phase = ST_RESET;
        end
      endcase
      if (pll_wr && st_ff.phase != ST_RESET && st_ff.phase != ST_WAIT) begin
        nxt_st.out_div = pll_wr_output_divider;
        nxt_st.f  = pll_wr_feedback_multiplier;
        nxt_st.r  = pll_wr_reference_divider;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{phase: ST_RESET, hiz: 1'b1, ss_n: 1'b1, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign gpio_hiz            = st_ff.hiz;
  assign gpio_pull_en        = st_ff.pulls;
  assign use_onchip_osc      = st_ff.onchip;
  // tile clock = osc * (mult+1)/2 / (ref_div+1) / (out_div+1), built by the analog pll
  assign output_divider      = st_ff.out_div;
  assign feedback_multiplier = st_ff.f;
  assign reference_divider   = st_ff.r;
  assign boot_source         = st_ff.src;
  assign ram_we              = st_ff.we;
  assign ram_addr            = st_ff.addr;
  assign ram_wdata           = st_ff.wdata;
  assign boot_done           = st_ff.done;
  assign boot_halted         = st_ff.halted;
  assign crc_error           = st_ff.err;
  assign start_addr          = 12'h000;
  assign spi_sclk            = st_ff.sclk;
  assign spi_ss_n            = st_ff.ss_n;
  assign spi_mosi            = st_ff.mosi;
endmodule

// ==== tb/boot_checker_assertions.sv ====
module boot_checker
  import boot_pkg::*;
#(
  parameter int unsigned WAIT_CLKS = RESET_WAIT_CLKS
)
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        chip_reset_n,
  input wire logic        pll_ratio_strap_lo,
  input wire logic        pll_ratio_strap_hi,
  input wire logic [1:0]  boot_source_straps,
  input wire logic        oscillator_source_strap,
  input wire logic [31:0] security_reg,
  input wire logic        spi_sclk,
  input wire logic        spi_ss_n,
  input wire logic        gpio_hiz,
  input wire logic        gpio_pull_en,
  input wire logic        use_onchip_osc,
  input wire logic [2:0]  output_divider,
  input wire logic [11:0] feedback_multiplier,
  input wire logic [5:0]  reference_divider,
  input wire logic [1:0]  boot_source,
  input wire logic        ram_we,
  input wire logic        boot_done,
  input wire logic        boot_halted,
  input wire logic [11:0] start_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  ratio;
  logic [19:0] wait_ff;
  assign ratio = {pll_ratio_strap_hi, pll_ratio_strap_lo};
  // cycles since the external reset was let go
  always_ff @(posedge clk or posedge rst) begin
    if (rst) wait_ff <= 20'h0_0000;
    else if (!chip_reset_n) wait_ff <= 20'h0_0000;
    else if (wait_ff != 20'hF_FFFF) wait_ff <= wait_ff + 20'h0_0001;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_hiz; !chip_reset_n |=> gpio_hiz; endproperty
  a_hiz: assert property (p_hiz) else $error("pins not high impedance in reset");
  property p_wait; $rose(gpio_pull_en) |->
    wait_ff >= 20'(WAIT_CLKS - 1) && wait_ff <= 20'(WAIT_CLKS + 3);
  endproperty
  a_wait: assert property (p_wait) else $error("pull enable at wrong count");
  property p_ratio; $rose(gpio_pull_en) |-> ##[0:2] (reference_divider == R_RESET &&
    {output_divider, feedback_multiplier} == (ratio == 2'b00 ? {OUT_DIV_R00, F_R00} :
    ratio == 2'b11 ? {OUT_DIV_R11, F_R11} : ratio == 2'b10 ? {OUT_DIV_R10, F_R10} :
    {OUT_DIV_R01, F_R01}));
  endproperty
  a_ratio: assert property (p_ratio) else $error("pll setting differs from straps");
  property p_src; $rose(gpio_pull_en) |-> ##[0:2] (use_onchip_osc == oscillator_source_strap &&
    boot_source == (security_reg[SECURE_BOOT_BIT] ? 2'b10 : boot_source_straps)); endproperty
  a_src: assert property (p_src) else $error("boot or clock source wrong");
  property p_idle; spi_ss_n |-> !spi_sclk; endproperty
  a_idle: assert property (p_idle) else $error("serial clock not low while idle");
  property p_half; $rose(spi_sclk) |-> spi_sclk [*8]; endproperty
  a_half: assert property (p_half) else $error("serial clock high phase too short");
  property p_otp; gpio_pull_en && security_reg[SECURE_BOOT_BIT] |-> spi_ss_n; endproperty
  a_otp: assert property (p_otp) else $error("flash selected in secure boot");
  property p_done; boot_done |-> start_addr == 12'h000 && !boot_halted; endproperty
  a_done: assert property (p_done) else $error("start address or halt wrong");
  property p_we; ram_we |=> !ram_we [*3]; endproperty
  a_we: assert property (p_we) else $error("word writes closer than four bytes");
  c_done: cover property (boot_done);
  c_halt: cover property (boot_halted);
  c_spi: cover property ($fell(spi_ss_n));
endmodule
bind reset_boot_pll_loader boot_checker #(.WAIT_CLKS(WAIT_CLKS)) chk_u (.clk, .rst, .chip_reset_n,
  .pll_ratio_strap_lo,
  .pll_ratio_strap_hi, .boot_source_straps, .oscillator_source_strap, .security_reg, .spi_sclk,
  .spi_ss_n, .gpio_hiz, .gpio_pull_en, .use_onchip_osc, .output_divider, .feedback_multiplier,
  .reference_divider, .boot_source, .ram_we, .boot_done, .boot_halted, .start_addr);

// ==== tb/spi_flash_model.sv ====
module spi_flash_model (
  input wire logic    sclk,
  input wire logic    ss_n,
  input wire logic    mosi,
  input logic [7:0]   img [12],
  output logic        miso,
  output logic [31:0] hdr
);
  timeunit 1ns;
  timeprecision 1ps;
  int   bitn = 0;
  logic q = 1'b0;
  // a deselected flash leaves the line: show the inverse of the last bit
  assign miso = ss_n ? ~q : q;
  always @(negedge ss_n) bitn = 0;
  always @(posedge sclk) if (!ss_n) begin
    if (bitn < 32) hdr <= {hdr[30:0], mosi};
    bitn <= bitn + 1;
  end
  always @(negedge sclk) if (!ss_n && bitn >= 32 && bitn < 128) begin
    q <= img[(bitn - 32) / 8][(bitn - 32) % 8];
  end
endmodule

// ==== tb/tb_reset_boot_pll_loader.sv ====
module tb_reset_boot_pll_loader
  import boot_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // shortened post-reset wait keeps every boot brief
  localparam int unsigned BOOT_WAIT = 1000;
  logic        clk, rst, chip_reset_n, pll_ratio_strap_lo, pll_ratio_strap_hi, pll_wr;
  logic        oscillator_source_strap, ext_byte_valid, spi_miso, spi_sclk, spi_ss_n, spi_mosi;
  logic        gpio_hiz, gpio_pull_en, use_onchip_osc, ram_we, boot_done, boot_halted, crc_error;
  logic [1:0]  boot_source_straps, boot_source;
  logic [2:0]  pll_wr_output_divider, output_divider;
  logic [5:0]  pll_wr_reference_divider, reference_divider;
  logic [11:0] pll_wr_feedback_multiplier, feedback_multiplier, ram_addr, start_addr;
  logic [31:0] security_reg, ram_wdata, hdr, mem [4];
  logic [7:0]  ext_byte_data, img [12], stream [$];
  logic [11:0] ftab [4] = '{12'h07A, 12'h017, 12'h031, 12'h077};
  int          nwr, error_cnt, checks_done, cyc;
  reset_boot_pll_loader #(.WAIT_CLKS(BOOT_WAIT)) dut_u (.clk, .rst, .chip_reset_n,
    .pll_ratio_strap_lo, .pll_ratio_strap_hi,
    .boot_source_straps, .oscillator_source_strap, .security_reg, .pll_wr, .pll_wr_output_divider,
    .pll_wr_feedback_multiplier, .pll_wr_reference_divider, .ext_byte_valid, .ext_byte_data,
    .spi_miso, .spi_sclk, .spi_ss_n, .spi_mosi, .gpio_hiz, .gpio_pull_en, .use_onchip_osc,
    .output_divider, .feedback_multiplier, .reference_divider, .boot_source, .ram_we, .ram_addr,
    .ram_wdata, .boot_done, .boot_halted, .crc_error, .start_addr);
  spi_flash_model flash_u (.sclk(spi_sclk), .ss_n(spi_ss_n), .mosi(spi_mosi), .img,
    .miso(spi_miso), .hdr);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (ram_we === 1'b1) begin
      mem[ram_addr[1:0]] <= ram_wdata;
      nwr++;
    end
    if (cyc == 32'h0000_7530) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // image: size, n words, then good, corrupted or skip check word
  task automatic build(int n, int mode);
    logic [31:0] c, w;
    stream = {};
    c = 32'hFFFF_FFFF;
    for (int k = 0; k <= n; k++) begin
      w = (k == 0) ? n : 32'hA5C3_0000 + k;
      for (int b = 0; b < 4; b++) stream.push_back(w[8*b+:8]);
    end
    foreach (stream[j]) begin
      c ^= {24'h00_0000, stream[j]};
      repeat (8) c = c[0] ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
    end
    w = (mode == 2) ? 32'h0D15_AB1E : (mode == 1) ? c : ~c;
    for (int b = 0; b < 4; b++) stream.push_back(w[8*b+:8]);
  endtask
  task automatic send();
    foreach (stream[j]) begin
      @(posedge clk);
      ext_byte_valid <= 1'b1;
      ext_byte_data <= stream[j];
    end
    @(posedge clk);
    ext_byte_valid <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic boot(logic [1:0] ratio, logic [1:0] src, logic sec, logic osc);
    @(posedge clk);
    chip_reset_n <= 1'b0;
    {pll_ratio_strap_hi, pll_ratio_strap_lo} <= ratio;
    boot_source_straps <= src;
    security_reg <= {26'h000_0000, sec, 5'h00};
    oscillator_source_strap <= osc;
    nwr = 0;
    repeat (3) @(posedge clk);
    #1 chk("gpio_hiz", gpio_hiz, 1'b1);
    @(posedge clk);
    chip_reset_n <= 1'b1;
    for (int i = 0; i < BOOT_WAIT + 16 && gpio_pull_en !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    repeat (3) @(posedge clk);
    #1 chk("pll", {output_divider, feedback_multiplier, reference_divider},
      {ratio == 2'b00 ? 3'h1 : 3'h2, ftab[ratio], 6'h00});
    chk("osc", use_onchip_osc, osc);
    chk("source", boot_source, sec ? 2'b10 : src);
    chk("pins", {gpio_hiz, gpio_pull_en}, 2'h1);
  endtask
  task automatic t_idle();
    for (int s = 0; s < 2; s++) begin
      boot(2'b01, s[1:0], 1'b0, s[0]);
      repeat (200) @(posedge clk);
      #1 chk("idle", {spi_ss_n, boot_done, nwr[3:0]}, 6'h20);
    end
    $display("test idle done");
  endtask
  task automatic t_link();
    build(2, 0);
    boot(2'b00, 2'b10, 1'b0, 1'b0);
    send();
    chk("writes", nwr, 2);
    chk("word0", mem[0], 32'hA5C3_0001);
    chk("word1", mem[1], 32'hA5C3_0002);
    chk("done", {boot_done, boot_halted, spi_ss_n, start_addr}, 15'h5000);
    @(posedge clk);
    pll_wr <= 1'b1;
    pll_wr_output_divider <= 3'h5;
    pll_wr_feedback_multiplier <= 12'h0FF;
    pll_wr_reference_divider <= 6'h03;
    @(posedge clk);
    pll_wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("pll write", {output_divider, feedback_multiplier, reference_divider},
      {3'h5, 12'h0FF, 6'h03});
    $display("test link done");
  endtask
  task automatic t_spi();
    build(1, 2);
    foreach (img[j]) img[j] = stream[j];
    boot(2'b11, 2'b11, 1'b0, 1'b1);
    for (int i = 0; i < 32'h0000_1F40 && boot_done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("command", hdr, 32'h0300_0000);
    chk("word0", mem[0], 32'hA5C3_0001);
    chk("done", {boot_done, nwr[3:0]}, 5'h11);
    $display("test spi done");
  endtask
  task automatic t_otp();
    build(1, 1);
    boot(2'b10, 2'b11, 1'b1, 1'b0);
    send();
    chk("halt", {boot_halted, crc_error, boot_done, spi_ss_n}, 4'hD);
    chk("writes", nwr, 1);
    $display("test otp done");
  endtask
  initial begin
    {error_cnt, checks_done, cyc, nwr} = '0;
    {rst, chip_reset_n, pll_ratio_strap_lo, pll_ratio_strap_hi, pll_wr} = 5'h10;
    {oscillator_source_strap, ext_byte_valid, boot_source_straps, security_reg} = '0;
    {pll_wr_output_divider, pll_wr_feedback_multiplier, pll_wr_reference_divider} = '0;
    ext_byte_data = 8'h00;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk("reset", {gpio_hiz, spi_ss_n}, 2'h3);
    t_idle();
    t_link();
    t_spi();
    t_otp();
    wrap_up();
  end
endmodule
